// ===== pkg/fsg_pkg.sv
/*
  Constants and types for the flash signature generator.
  Assumes a 32-bit AHB-Lite register bus and a 250 MHz system clock.
*/
package fsg_pkg;
  // Bus and datapath widths
  localparam int DATA_W = 32;
  localparam int HADDR_W = 12;
  localparam int WADDR_W = 17;
  localparam int SIG_W = 128;
  localparam int CHK_W_DEF = 8;
  localparam int CNT_W = 5;
  // Register byte offsets
  localparam logic [HADDR_W-1:0] OFS_FIRST = 12'h020;
  localparam logic [HADDR_W-1:0] OFS_LAST = 12'h024;
  localparam logic [HADDR_W-1:0] OFS_RES0 = 12'h02c;
  localparam logic [HADDR_W-1:0] OFS_RES1 = 12'h030;
  localparam logic [HADDR_W-1:0] OFS_RES2 = 12'h034;
  localparam logic [HADDR_W-1:0] OFS_RES3 = 12'h038;
  localparam logic [HADDR_W-1:0] OFS_STATE = 12'hfe0;
  localparam logic [HADDR_W-1:0] OFS_IRQ_EN = 12'hfe4;
  localparam logic [HADDR_W-1:0] OFS_CLEAR = 12'hfe8;
  // Field positions
  localparam int RUN_BIT = 17;
  localparam int DONE_BIT = 0;
  localparam int BUSY_BIT = 1;
  localparam int HTRANS_ACT_BIT = 1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // Timing: per-word budget in system clocks
  localparam int CLK_PERIOD_NS = 4;
  localparam int FLASH_ACC_NS = 60;
  localparam int WORD_EXTRA = 3;
  localparam int WORD_CYCLES = FLASH_ACC_NS / CLK_PERIOD_NS + WORD_EXTRA;
  localparam int RD_CAP = WORD_CYCLES - 4;
  // Feedback taps of the signature register
  localparam int TAP_A = 0;
  localparam int TAP_B = 2;
  localparam int TAP_C = 27;
  localparam int TAP_D = 29;
  // Sequencer states
  typedef enum logic [2:0] {
    FSG_IDLE = 3'h1,
    FSG_ISSUE = 3'h2,
    FSG_WAIT = 3'h4
  } fsg_state_t;
endpackage

// ===== pkg/fsg_word_if.sv
/*
  Word hand-off from the flash reader to the signature register.
  Assumes both ends share hclk; valid is a one-cycle pulse.
*/
`timescale 1ns/1ps
interface fsg_word_if #(parameter int W = 128);
  logic valid; // Word present this cycle
  logic [W-1:0] word; // Folded flash word
  modport src(output valid, output word);
  modport dst(input valid, input word);
endinterface

// ===== rtl/fsg_misr.sv
/*
  128-bit multiple-input signature register.
  Assumes clear and word pulses never coincide with a pending reset.
*/
`timescale 1ns/1ps
module fsg_misr
  import fsg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  fsg_word_if.dst wi,
  output logic [fsg_pkg::SIG_W-1:0] sig
);
  typedef struct packed {
    logic [SIG_W-1:0] sig;
  } fsg_misr_state_t;

  fsg_misr_state_t s_reg, s_next;

  // One shift with tap feedback into the top bit
  function automatic logic [SIG_W-1:0] fsg_step(input logic [SIG_W-1:0] cur,
                                                input logic [SIG_W-1:0] w);
    logic [SIG_W-1:0] nx;
    nx = w ^ {1'b0, cur[SIG_W-1:1]};
    nx[SIG_W-1] = nx[SIG_W-1] ^ cur[TAP_A] ^ cur[TAP_B] ^ cur[TAP_C] ^ cur[TAP_D];
    return nx;
  endfunction

  // Clear to zero at run start, else fold each word
  always_comb begin
    s_next = s_reg;
    if (clear) begin
      s_next.sig = '0; // [RQ1]
    end else if (wi.valid) begin
      s_next.sig = fsg_step(s_reg.sig, wi.word); // [RQ13]
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sig = s_reg.sig;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_misr_clear: assert property (clear |=> sig == '0) // [RQ13]
    else $error("signature not zero after clear");
  chk_misr_tap: assert property (wi.valid && !clear |=> sig[SIG_W-1] == // [RQ13]
    ($past(wi.word[SIG_W-1]) ^ $past(sig[TAP_A]) ^ $past(sig[TAP_B])
     ^ $past(sig[TAP_C]) ^ $past(sig[TAP_D])))
    else $error("top signature bit feedback wrong");
endmodule

// ===== rtl/fsg_flash_rd.sv
/*
  Self-timed flash word reader.
  Assumes the flash raises done asynchronously once data and check bits
  are stable, and drops it after the read enable falls.
*/
`timescale 1ns/1ps
module fsg_flash_rd
  import fsg_pkg::*;
#(
  parameter int CHK_W = CHK_W_DEF
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic [fsg_pkg::WADDR_W-1:0] addr,
  output logic flash_rd_en,
  output logic [fsg_pkg::WADDR_W-1:0] flash_rd_addr,
  input wire logic [fsg_pkg::SIG_W-1:0] flash_rd_data,
  input wire logic [CHK_W-1:0] flash_rd_check,
  input wire logic flash_rd_done,
  fsg_word_if.src wo
);
  typedef struct packed {
    logic en; // Read enable to flash
    logic [WADDR_W-1:0] addr; // Word address held
    logic sync1; // Done synchroniser, first stage
    logic sync2; // Done synchroniser, second stage
    logic seen_low; // Stale done from last word has gone
    logic [CNT_W-1:0] cnt; // Cycles spent in this read
    logic valid; // Word pulse
    logic [SIG_W-1:0] word; // Captured word
  } fsg_rd_state_t;

  fsg_rd_state_t s_reg, s_next;

  // Read sequencing; timing comes from the flash, not a wait setting
  always_comb begin
    s_next = s_reg;
    s_next.sync1 = flash_rd_done;
    s_next.sync2 = s_reg.sync1;
    s_next.valid = 1'b0;
    if (start) begin
      s_next.en = 1'b1; // [RQ7]
      s_next.addr = addr;
      s_next.cnt = '0;
      s_next.seen_low = 1'b0;
    end else if (s_reg.en) begin
      if (!s_reg.sync2) begin
        s_next.seen_low = 1'b1;
      end
      // Done seen, or budget used up so the run stays bounded
      if ((s_reg.seen_low && s_reg.sync2) || s_reg.cnt == CNT_W'(RD_CAP)) begin // [RQ7] [RQ8]
        s_next.en = 1'b0;
        s_next.valid = 1'b1;
        // Check bits folded into the low end of the word
        s_next.word = flash_rd_data ^ {{(SIG_W-CHK_W){1'b0}}, flash_rd_check}; // [RQ11] [RQ12]
      end else begin
        s_next.cnt = s_reg.cnt + CNT_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign flash_rd_en = s_reg.en;
  assign flash_rd_addr = s_reg.addr;
  assign wo.valid = s_reg.valid;
  assign wo.word = s_reg.word;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_read_budget: assert property (s_reg.en |-> s_reg.cnt <= CNT_W'(RD_CAP)) // [RQ8]
    else $error("flash read ran past its budget");
  chk_valid_ends: assert property (s_reg.valid |-> !s_reg.en ##1 !s_reg.valid) // [RQ17]
    else $error("word pulse not single or read still on");
endmodule

// ===== rtl/fsg_top.sv
/*
  Flash signature generator: AHB-Lite register slave, run sequencer,
  flash reader and signature register.
  Only haddr[11:0] is decoded; reads cost one wait state, writes none.
  Assumes a single AHB-Lite slave whose hreadyout is the bus hready,
  and a flash read port that stalls while flash_bus_hold is high.
  Assumes flash_rd_done comes from a self-timed flash in no fixed phase
  with hclk; it is resynchronised inside the reader.
  Assumes the range limits are whole flash words, as software programs them.
*/
// The AHB-Lite slave port and the placing of the registers were decided locally.
// Function
// RQ1 - One 128-bit signature over a range
// RQ2 - Software gives flash-word aligned limits
// RQ3 - Run finishes alone once started
// RQ4 - Bus flash reads stall during run
// RQ5 - Software writes first and last word
// RQ6 - Run bit with last address, one write
// RQ7 - Flash reads self-timed, no wait setting
// RQ8 - Run time bounded per word
// RQ9 - Done flag set at run end
// RQ10 - Signature readable as four words
// RQ11 - Signature uses corrected read data
// RQ12 - Signature also covers check bits
// RQ13 - Shift with taps 0,2,27,29 from zero
// RQ14 - Start code should run outside flash
// RQ15 - Address fields 17 bits, byte/16
// RQ16 - Run bit is bit 17
// RQ17 - Words ascending, first through last
`timescale 1ns/1ps
module fsg_top
  import fsg_pkg::*;
#(
  parameter int CHK_W = CHK_W_DEF
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [fsg_pkg::DATA_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [fsg_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [fsg_pkg::DATA_W-1:0] hrdata,
  output logic hresp,
  output logic irq,
  output logic flash_bus_hold,
  output logic flash_rd_en,
  output logic [fsg_pkg::WADDR_W-1:0] flash_rd_addr,
  input wire logic [fsg_pkg::SIG_W-1:0] flash_rd_data,
  input wire logic [CHK_W-1:0] flash_rd_check,
  input wire logic flash_rd_done
);
  typedef struct packed {
    fsg_state_t state; // Run sequencer
    logic [WADDR_W-1:0] first; // First word of range
    logic [WADDR_W-1:0] last; // Last word of range
    logic [WADDR_W-1:0] cur; // Word now being read
    logic done; // Sticky completion flag
    logic irq_en; // Completion interrupt enable
    logic wr_pend; // Write data phase next
    logic rd_pend; // Read wait cycle next
    logic [HADDR_W-1:0] acc_addr; // Address phase captured
    logic [DATA_W-1:0] hrdata; // Read data out
    logic hready_o; // Ready out
    logic hresp; // Response out, always OKAY
    logic irq; // Interrupt out
    logic hold; // Flash bus stall out
    logic [CNT_W-1:0] wcyc; // Cycles spent on the current word
  } fsg_top_state_t;

  // Reset image: ready high so the bus never stalls in reset
  localparam fsg_top_state_t TOP_RST = '{state: FSG_IDLE, hready_o: 1'b1, default: '0};

  fsg_top_state_t s_reg, s_next;
  // Strobes worked out in the combinational block
  logic start_run; // Run accepted this cycle
  logic acc; // Address phase taken this cycle
  logic [SIG_W-1:0] sig; // Current signature
  logic issue; // Start one flash read

  // Data path: the reader fetches one word per issue and pulses it over
  // word_bus; the signature register folds each pulse. The sequencer
  // below only steps the address and decides when the run is over.
  fsg_word_if #(.W(SIG_W)) word_bus();

  // Flash word reader
  fsg_flash_rd #(.CHK_W(CHK_W)) u_rd (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(issue),
    .addr(s_reg.cur),
    .flash_rd_en(flash_rd_en),
    .flash_rd_addr(flash_rd_addr),
    .flash_rd_data(flash_rd_data),
    .flash_rd_check(flash_rd_check),
    .flash_rd_done(flash_rd_done),
    .wo(word_bus)
  );

  // Signature register
  fsg_misr u_misr (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(start_run),
    .wi(word_bus),
    .sig(sig)
  );

  assign issue = (s_reg.state == FSG_ISSUE);

  // Register read mux, used in the read wait cycle
  // Map, one aligned word per register:
  //   first word - range start, bits 16:0, locked during a run
  //   last word - range end, bits 16:0; bit 17 starts, reads as busy
  //   result 0..3 - signature, lowest bits at the lowest offset
  //   state - bit 0 sticky done, bit 1 busy
  //   irq enable - bit 0 gates done onto irq
  //   clear - write 1 to bit 0 to drop done; reads as zero
  function automatic logic [DATA_W-1:0] fsg_read(input fsg_top_state_t s,
                                                 input logic [SIG_W-1:0] sg);
    logic busy;
    // Busy shows in the run bit position and in the state word
    busy = (s.state != FSG_IDLE);
    case (s.acc_addr)
      OFS_FIRST: return DATA_W'(s.first); // [RQ15]
      OFS_LAST: return DATA_W'({busy, s.last}); // [RQ16]
      OFS_RES0: return sg[DATA_W-1:0]; // [RQ10]
      OFS_RES1: return sg[2*DATA_W-1:DATA_W];
      OFS_RES2: return sg[3*DATA_W-1:2*DATA_W];
      OFS_RES3: return sg[4*DATA_W-1:3*DATA_W];
      OFS_STATE: return DATA_W'({busy, s.done});
      OFS_IRQ_EN: return DATA_W'(s.irq_en);
      default: return '0;
    endcase
  endfunction

  // Bus slave, register writes and run sequencer
  // Write: address phase, then data phase; the register changes at the
  // edge that ends the data phase, with no wait state.
  // Read: address phase, one wait cycle in which the mux is sampled,
  // then hrdata stands with hreadyout high until the next read answer.
  always_comb begin
    s_next = s_reg;
    start_run = 1'b0;
    // Address phase: reads take one wait state so a prior write has landed
    // Non-word writes are ignored; reads of any size are answered
    acc = hsel && hready && htrans[HTRANS_ACT_BIT];
    s_next.wr_pend = acc && hwrite && (hsize == HSIZE_WORD);
    s_next.rd_pend = acc && !hwrite;
    s_next.hready_o = !(acc && !hwrite);
    if (acc) begin
      s_next.acc_addr = haddr[HADDR_W-1:0];
    end
    // Read wait cycle: fetch the answer
    // The mux sees this cycle's state, so busy and done are current
    if (s_reg.rd_pend) begin
      s_next.hrdata = fsg_read(s_reg, sig);
    end
    // Write data phase; range is locked while a run is on
    if (s_reg.wr_pend) begin
      case (s_reg.acc_addr)
        OFS_FIRST: begin
          // Range start; a write during a run is dropped
          if (s_reg.state == FSG_IDLE) begin
            s_next.first = hwdata[WADDR_W-1:0]; // [RQ15]
          end
        end
        OFS_LAST: begin
          // Range end and run bit in one write; dropped during a run
          if (s_reg.state == FSG_IDLE) begin
            s_next.last = hwdata[WADDR_W-1:0]; // [RQ6] [RQ15]
            start_run = hwdata[RUN_BIT]; // [RQ6] [RQ16]
          end
        end
        OFS_IRQ_EN: begin
          // Interrupt enable, free to change at any time
          s_next.irq_en = hwdata[DONE_BIT];
        end
        OFS_CLEAR: begin
          // Clear done; a set later in this block still wins
          if (hwdata[DONE_BIT]) begin
            s_next.done = 1'b0;
          end
        end
        default: begin
          // Unmapped or read-only: write dropped
        end
      endcase
    end
    // Sequencer; done set last so it beats a clear in the same cycle
    // Per word: one issue cycle, then wait for the reader's pulse. The
    // reader gives up after its own cap, so a silent flash cannot hang
    // the run and software always sees done in bounded time.
    unique case (s_reg.state)
      FSG_IDLE: begin
        // Only an accepted run bit leaves idle
        if (start_run) begin
          s_next.state = FSG_ISSUE; // [RQ3]
          s_next.cur = s_reg.first; // [RQ17]
          s_next.done = 1'b0;
        end
      end
      FSG_ISSUE: begin
        // Reader latches cur on this cycle
        s_next.state = FSG_WAIT;
      end
      FSG_WAIT: begin
        if (word_bus.valid) begin
          if (s_reg.cur == s_reg.last) begin
            // Last word folded: run over
            s_next.state = FSG_IDLE;
            s_next.done = 1'b1; // [RQ9]
          end else begin
            // More words: step up by one
            s_next.cur = s_reg.cur + WADDR_W'(1); // [RQ17]
            s_next.state = FSG_ISSUE; // [RQ3]
          end
        end
      end
    endcase
    // Per-word cycle count, only watched by the budget check
    // Saturates so a stuck word still fails the check rather than wrapping
    if (issue) begin
      s_next.wcyc = '0;
    end else if (s_reg.wcyc != '1) begin
      s_next.wcyc = s_reg.wcyc + CNT_W'(1);
    end
    // Outputs follow the next state so they stay in step
    s_next.hold = (s_next.state != FSG_IDLE); // [RQ4]
    s_next.irq = s_next.done && s_next.irq_en;
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= TOP_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Ports straight from the state register
  assign hreadyout = s_reg.hready_o;
  assign hrdata = s_reg.hrdata;
  assign hresp = s_reg.hresp;
  assign irq = s_reg.irq;
  assign flash_bus_hold = s_reg.hold;

  // Checks on the bus, the sequencer and the run bound
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Run start and run bit
  chk_run_start: assert property (s_reg.wr_pend && s_reg.acc_addr == OFS_LAST // [RQ6]
    && hwdata[RUN_BIT] && s_reg.state == FSG_IDLE |=> flash_bus_hold ##1 flash_rd_en)
    else $error("run bit did not start a run");
  chk_run_bit_low: assert property (s_reg.wr_pend && s_reg.acc_addr == OFS_LAST // [RQ16]
    && !hwdata[RUN_BIT] && s_reg.state == FSG_IDLE |=> !flash_bus_hold)
    else $error("run started without the run bit");
  // Hold and reader enable
  chk_hold_done: assert property ($fell(flash_bus_hold) |-> s_reg.done) // [RQ4] [RQ9]
    else $error("hold dropped without done");
  chk_en_in_run: assert property (flash_rd_en |-> flash_bus_hold) // [RQ4]
    else $error("flash read outside a run");
  // Per word timing and order
  chk_word_budget: assert property (s_reg.state == FSG_WAIT // [RQ8]
    |-> s_reg.wcyc < WORD_CYCLES)
    else $error("word took longer than its budget");
  chk_addr_step: assert property (s_reg.state == FSG_WAIT && word_bus.valid // [RQ17]
    && s_reg.cur != s_reg.last |=> s_reg.cur == $past(s_reg.cur) + WADDR_W'(1))
    else $error("word address did not step by one");
  chk_rd_addr_cur: assert property (flash_rd_en |-> flash_rd_addr == s_reg.cur) // [RQ17]
    else $error("flash read address not the current word");
  chk_next_issue: assert property (s_reg.state == FSG_WAIT && word_bus.valid // [RQ3]
    && s_reg.cur != s_reg.last |=> s_reg.state == FSG_ISSUE)
    else $error("run stalled between words");
  chk_last_done: assert property (s_reg.state == FSG_WAIT && word_bus.valid // [RQ9]
    && s_reg.cur == s_reg.last |=> s_reg.done && !flash_bus_hold)
    else $error("last word did not end the run");
  // Flags and result
  chk_done_sticky: assert property (s_reg.done && !start_run && !(s_reg.wr_pend // [RQ9]
    && s_reg.acc_addr == OFS_CLEAR && hwdata[DONE_BIT]) |=> s_reg.done)
    else $error("done flag dropped without a clear");
  chk_irq_level: assert property (s_reg.done && s_reg.irq_en |-> irq)
    else $error("enabled done flag without interrupt");
  chk_sig_frozen: assert property (s_reg.state == FSG_IDLE && !start_run // [RQ10]
    |=> $stable(sig))
    else $error("signature moved while idle");
  // Bus timing: one wait per read, none per write, data held
  // between answers, response always OKAY
  chk_read_wait: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read answer timing wrong");
  chk_write_nowait: assert property (acc && hwrite |=> hreadyout)
    else $error("write stalled the bus");
  chk_hrdata_hold: assert property (!s_reg.rd_pend |=> $stable(hrdata))
    else $error("read data changed outside an answer");
  chk_resp_okay: assert property (!hresp)
    else $error("response not OKAY");
  // Range lock: both limits hold still while a run is on
  chk_range_lock: assert property (flash_bus_hold |=> $stable(s_reg.last)) // [RQ3]
    else $error("range changed during a run");
  chk_first_lock: assert property (s_reg.state != FSG_IDLE |=> $stable(s_reg.first)) // [RQ3]
    else $error("range start changed during a run");
endmodule

// ===== bench/fsg_flash_model.sv
/*
  Flash array model: answers word reads after a set number of cycles.
  Assumes the reader holds rd_en and rd_addr until it has the word.
*/
`timescale 1ns/1ps
module fsg_flash_model
  import fsg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] lat,
  input wire logic rd_en,
  input wire logic [fsg_pkg::WADDR_W-1:0] rd_addr,
  output logic [fsg_pkg::SIG_W-1:0] rd_data,
  output logic [7:0] rd_check,
  output logic rd_done
);
  logic [3:0] cnt_reg; // Cycles since enable rose
  // Content pattern derived from the word address
  function automatic logic [SIG_W-1:0] fw(input logic [WADDR_W-1:0] a);
    return {a, 15'h1234, ~a, 15'h4321, a, 15'h0f0f, ~a, 15'h7a5a};
  endfunction
  // Self-timed ready, dropped once the enable falls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 4'h0;
      rd_done <= 1'b0;
    end else if (!rd_en) begin
      cnt_reg <= 4'h0;
      rd_done <= 1'b0;
    end else if (cnt_reg < lat) begin
      cnt_reg <= cnt_reg + 4'h1;
    end else begin
      rd_done <= 1'b1;
    end
  end
  // Data inverted while not ready, so a stale word never matches
  assign rd_data = rd_done ? fw(rd_addr) : ~fw(rd_addr);
  assign rd_check = rd_done ? (rd_addr[7:0] ^ 8'ha5) : ~(rd_addr[7:0] ^ 8'ha5);
endmodule

// ===== bench/fsg_top_tb.sv
/*
  Self-checking bench for the signature generator over AHB-Lite.
  Assumes fsg_flash_model stands in for the flash array.
*/
`timescale 1ns/1ps
module fsg_top_tb;
  import fsg_pkg::*;
  logic hclk = 0; // 250 MHz clock
  logic hresetn = 0; // Reset, active low
  logic hsel = 0;
  logic hwrite = 0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] lat = 4'h1; // Flash answer delay
  logic hreadyout, hresp, irq, flash_bus_hold, flash_rd_en, flash_rd_done;
  logic [31:0] hrdata;
  logic [WADDR_W-1:0] flash_rd_addr;
  logic [WADDR_W-1:0] next_addr = '0; // Next word expected
  logic [SIG_W-1:0] flash_rd_data;
  logic [7:0] flash_rd_check;
  logic en_q = 0; // Enable of the last cycle
  int mismatches = 0;
  int tests_run = 0;
  int words = 0; // Words read in this run
  int hold_cyc = 0; // Cycles with the bus hold up
  logic [11:0] zaddr [5] = '{OFS_FIRST, OFS_LAST, OFS_STATE, OFS_IRQ_EN, 12'h100};

  always #2 hclk = ~hclk;

  fsg_top #(.CHK_W(8)) i_fsg_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq),
    .flash_bus_hold(flash_bus_hold), .flash_rd_en(flash_rd_en),
    .flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data),
    .flash_rd_check(flash_rd_check), .flash_rd_done(flash_rd_done));
  fsg_flash_model i_fsg_flash_model (.hclk(hclk), .hresetn(hresetn), .lat(lat),
    .rd_en(flash_rd_en), .rd_addr(flash_rd_addr), .rd_data(flash_rd_data),
    .rd_check(flash_rd_check), .rd_done(flash_rd_done));

  // Same content pattern as the flash model
  function automatic logic [SIG_W-1:0] fw(input logic [WADDR_W-1:0] a);
    return {a, 15'h1234, ~a, 15'h4321, a, 15'h0f0f, ~a, 15'h7a5a};
  endfunction
  // One signature step
  function automatic logic [SIG_W-1:0] fold(input logic [SIG_W-1:0] s, w);
    return {w[127] ^ s[0] ^ s[2] ^ s[27] ^ s[29], w[126:0] ^ s[127:1]};
  endfunction

  task chk32(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task chk1(input string nm, input logic e, g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %b, seen %b", nm, e, g);
    end
  endtask

  // One single AHB transfer, address phase then data phase
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
            output logic [31:0] rdv);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task rd(input logic [11:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0, d);
  endtask

  // Watch word addresses and run length
  always @(posedge hclk) begin
    en_q <= flash_rd_en;
    if (flash_bus_hold === 1'b1)
      hold_cyc++;
    if (flash_rd_en === 1'b1 && !en_q) begin
      chk32("word address", {15'h0, next_addr}, {15'h0, flash_rd_addr});
      next_addr++;
      words++;
    end
  end

  // Full run: program, start, poll, read and clear
  task run_sig(input logic [16:0] f, l, input logic [3:0] lt, input logic ie);
    logic [SIG_W-1:0] e;
    logic [31:0] d;
    int n;
    e = '0;
    n = int'(l - f) + 1;
    wr(OFS_IRQ_EN, {31'h0, ie});
    lat <= lt;
    wr(OFS_FIRST, {15'h0, f});
    for (int k = 0; k < n; k++)
      e = fold(e, fw(f + 17'(k)) ^ {120'h0, 8'(f + 17'(k)) ^ 8'ha5});
    next_addr = f;
    words = 0;
    hold_cyc = 0;
    wr(OFS_LAST, {14'h0, 1'b1, l});
    #1;
    chk1("bus hold", 1'b1, flash_bus_hold);
    wr(OFS_FIRST, 32'h0001ffff);
    rd(OFS_LAST, d);
    chk32("busy readback", {14'h0, 1'b1, l}, d & 32'h3ffff);
    // Poll over the register bus, never from the stalled flash
    do rd(OFS_STATE, d); while (d[DONE_BIT] !== 1'b1);
    chk32("state", 32'h1, d);
    chk32("word count", n, words);
    chk1("run time", 1'b1, hold_cyc <= (60 / 4 + 3) * n);
    chk1("irq", ie, irq);
    for (int k = 0; k < 4; k++) begin
      rd(OFS_RES0 + 12'(4 * k), d);
      chk32("signature word", e[32*k +: 32], d);
    end
    rd(OFS_FIRST, d);
    chk32("first word", {15'h0, f}, d & 32'h1ffff);
    wr(OFS_CLEAR, 32'h1);
    rd(OFS_STATE, d);
    chk32("cleared state", 32'h0, d);
    chk1("irq cleared", 1'b0, irq);
  endtask

  task close_out;
    $display("checks run %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial begin
    logic [31:0] d;
    repeat (6) @(posedge hclk);
    chk1("ready in reset", 1'b1, hreadyout);
    chk1("irq in reset", 1'b0, irq);
    hresetn <= 1'b1;
    foreach (zaddr[i]) begin
      rd(zaddr[i], d);
      chk32("reset value", 32'h0, d);
    end
    chk1("response", 1'b0, hresp);
    wr(OFS_LAST, 32'h00000005);
    #1;
    chk1("hold without run bit", 1'b0, flash_bus_hold);
    rd(OFS_LAST, d);
    chk32("last word", 32'h5, d);
    run_sig(17'h5, 17'h5, 4'h1, 1'b1);
    run_sig(17'h3, 17'ha, 4'h9, 1'b1);
    run_sig(17'h1fffc, 17'h1ffff, 4'h2, 1'b0);
    close_out;
  end

  // Watchdog against a hang
  initial begin
    #(4 * 20000);
    mismatches++;
    close_out;
  end
endmodule
